// ### pkg/msad_cfg.svh
// Address map bounds, chip-select area constants and timing counts for the mode select address decoder.
// Assumes a 32-bit byte address from the bus masters; each bound is the first address of a range.
`ifndef MSAD_CFG_SVH
`define MSAD_CFG_SVH

`define MSAD_RAM_LIMIT     32'h0004_0000
`define MSAD_PERI_A_BASE   32'h0008_0000
`define MSAD_SBY_BASE      32'h000A_4000
`define MSAD_PERI_B_BASE   32'h000A_6000
`define MSAD_DFL_BASE      32'h0010_0000
`define MSAD_DFL_LIMIT     32'h0010_8000
`define MSAD_FCMD_BASE     32'h007E_0000
`define MSAD_FCMD_LIMIT    32'h007F_0004
`define MSAD_PERI_C_BASE   32'h007F_C000
`define MSAD_EXPRAM_BASE   32'h0080_0000
`define MSAD_EXPRAM_LIMIT  32'h0086_0000
`define MSAD_CS_BASE       32'h0100_0000
`define MSAD_SDRAM_BASE    32'h0800_0000
`define MSAD_SDRAM_LIMIT   32'h1000_0000
`define MSAD_OPT_BASE      32'hFE7F_5D00
`define MSAD_OPT_LIMIT     32'hFE7F_5D80
`define MSAD_ROMRO_BASE    32'hFE7F_7D70
`define MSAD_ROMRO_LIMIT   32'hFE7F_7DA0
`define MSAD_CS0_BASE      32'hFF00_0000
`define MSAD_CFL_BASE      32'hFFE0_0000

// Chip-select areas 7..1 sit in 16 MB steps; index = CS_TOP - address bits 26:24.
`define MSAD_CS_TOP        4'h8
`define MSAD_CS_COUNT      8

// Cycles the pin synchroniser needs to fill before the strap may be taken.
`define MSAD_STRAP_FILL    2'h3

`endif

// ### pkg/msad_pkg.sv
// Types shared by the mode select address decoder modules.
// Assumes the constants of msad_cfg.svh for all numeric bounds.
package msad_pkg;

  // Boot mode as encoded on the two mode-setting pins.
  typedef enum logic [1:0] {
    MSAD_BOOT_SINGLE = 2'h0,
    MSAD_BOOT_SERIAL = 2'h1,
    MSAD_BOOT_USB    = 2'h2,
    MSAD_BOOT_DEBUG  = 2'h3
  } msad_boot_t;

  // Running mode chosen by register setting.
  typedef enum logic [1:0] {
    MSAD_RUN_SINGLE    = 2'h0,
    MSAD_RUN_EXT_ROM   = 2'h1,
    MSAD_RUN_EXT_NOROM = 2'h2
  } msad_run_t;

  // Decoded target, one-hot.
  typedef enum logic [11:0] {
    MSAD_TGT_NONE    = 12'h001,
    MSAD_TGT_RAM     = 12'h002,
    MSAD_TGT_PERIPH  = 12'h004,
    MSAD_TGT_STANDBY = 12'h008,
    MSAD_TGT_EXPRAM  = 12'h010,
    MSAD_TGT_DFLASH  = 12'h020,
    MSAD_TGT_FCMD    = 12'h040,
    MSAD_TGT_OPTMEM  = 12'h080,
    MSAD_TGT_ROMRO   = 12'h100,
    MSAD_TGT_CFLASH  = 12'h200,
    MSAD_TGT_EXTCS   = 12'h400,
    MSAD_TGT_SDRAM   = 12'h800
  } msad_target_t;

  // Strap capture sequence, one-hot.
  typedef enum logic [2:0] {
    MSAD_ST_FILL    = 3'h1,
    MSAD_ST_CAPTURE = 3'h2,
    MSAD_ST_RUN     = 3'h4
  } msad_state_t;

endpackage : msad_pkg

// ### pkg/msad_mode_if.sv
// Mode information passed from the mode controller to the decoder and the top.
// Assumes all members change only on clk_sys.
`timescale 1ns/1ns
`default_nettype none
interface msad_mode_if;
  msad_pkg::msad_boot_t bootMode;
  msad_pkg::msad_run_t  runMode;
  logic                 strapDone;

  modport ctrl (output bootMode, output runMode, output strapDone);
  modport dec  (input runMode, input strapDone);
  modport top  (input bootMode, input runMode, input strapDone);
endinterface : msad_mode_if
`default_nettype wire

// ### rtl/msad_mode_ctrl.sv
// Mode controller: takes the boot mode from the pins after reset and holds the running mode.
// Assumes modePin is asynchronous to clk_sys and runModeWr is a one-cycle pulse on clk_sys.
`timescale 1ns/1ns
`default_nettype none
`include "msad_cfg.svh"
module msad_mode_ctrl (
  input  wire logic       clk_sys,
  input  wire logic       rst_b,
  input  wire logic       clkEn,
  input  wire logic [1:0] modePin,
  input  wire logic       runModeWr,
  input  wire logic [1:0] runModeVal,
  msad_mode_if.ctrl       mode
);
  logic [1:0]           pinSync1;
  logic [1:0]           pinSync2;
  logic [1:0]           pinSync3;
  logic [1:0]           fillCnt;
  msad_pkg::msad_state_t state;
  msad_pkg::msad_state_t next_state;
  wire                  pinsAgree = (pinSync2 == pinSync3);
  wire                  fillDone  = (fillCnt == `MSAD_STRAP_FILL);
  // Only single-chip pin mode lets software move to an extended mode; values 3 are refused.
  wire                  runAccept = runModeWr && (state == msad_pkg::MSAD_ST_RUN) &&
                                    (mode.bootMode == msad_pkg::MSAD_BOOT_SINGLE) &&
                                    (runModeVal != 2'h3);

  // Three-stage pin synchroniser; the first stage feeds only the second.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pinSync1 <= 2'h0;
      pinSync2 <= 2'h0;
      pinSync3 <= 2'h0;
      fillCnt  <= 2'h0;
    end else if (clkEn) begin
      pinSync1 <= modePin;
      pinSync2 <= pinSync1;
      pinSync3 <= pinSync2;
      if (!fillDone) fillCnt <= fillCnt + 2'h1;
    end
  end

  // Strap sequence: wait for the synchroniser, take the pins once both late stages agree.
  always_comb begin
    next_state = state;
    case (state)
      msad_pkg::MSAD_ST_FILL:    if (fillDone) next_state = msad_pkg::MSAD_ST_CAPTURE;
      msad_pkg::MSAD_ST_CAPTURE: if (pinsAgree) next_state = msad_pkg::MSAD_ST_RUN;
      msad_pkg::MSAD_ST_RUN:     next_state = msad_pkg::MSAD_ST_RUN;
      default:                   next_state = msad_pkg::MSAD_ST_FILL;
    endcase
  end

  // Boot mode is caught after reset release, never under the reset itself.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state          <= msad_pkg::MSAD_ST_FILL;
      mode.bootMode  <= msad_pkg::MSAD_BOOT_SINGLE;
      mode.runMode   <= msad_pkg::MSAD_RUN_SINGLE;
      mode.strapDone <= 1'b0;
    end else if (clkEn) begin
      state <= next_state;
      if (state == msad_pkg::MSAD_ST_CAPTURE && pinsAgree) begin
        mode.bootMode  <= msad_pkg::msad_boot_t'(pinSync3);
        mode.strapDone <= 1'b1;
      end
      if (runAccept) mode.runMode <= msad_pkg::msad_run_t'(runModeVal);
    end
  end
endmodule : msad_mode_ctrl
`default_nettype wire

// ### rtl/msad_region_dec.sv
// Combinational address decoder for the three running modes.
// Assumes a stable address from the top's request register and mode from the mode controller.
`timescale 1ns/1ns
`default_nettype none
`include "msad_cfg.svh"
module msad_region_dec (
  input  wire logic [31:0]          addr,
  input  wire logic                 standbyGate,
  msad_mode_if.dec                  mode,
  output msad_pkg::msad_target_t    target,
  output logic [2:0]                csIndex
);
  // Mode qualifiers.
  wire ext   = (mode.runMode != msad_pkg::MSAD_RUN_SINGLE);
  wire romOn = (mode.runMode != msad_pkg::MSAD_RUN_EXT_NOROM);

  // Range hits; each range runs from its base up to its own limit or the next base, except CS0 and code flash, which run to the top.
  wire inRam  = addr <  `MSAD_RAM_LIMIT;
  wire inPerA = addr >= `MSAD_PERI_A_BASE && addr < `MSAD_SBY_BASE;
  wire inSby  = addr >= `MSAD_SBY_BASE    && addr < `MSAD_PERI_B_BASE;
  wire inPerB = addr >= `MSAD_PERI_B_BASE && addr < `MSAD_DFL_BASE;
  wire inDfl  = addr >= `MSAD_DFL_BASE    && addr < `MSAD_DFL_LIMIT;
  wire inFcmd = addr >= `MSAD_FCMD_BASE   && addr < `MSAD_FCMD_LIMIT;
  wire inPerC = addr >= `MSAD_PERI_C_BASE && addr < `MSAD_EXPRAM_BASE;
  wire inExp  = addr >= `MSAD_EXPRAM_BASE && addr < `MSAD_EXPRAM_LIMIT;
  wire inCs   = addr >= `MSAD_CS_BASE     && addr < `MSAD_SDRAM_BASE;
  wire inSd   = addr >= `MSAD_SDRAM_BASE  && addr < `MSAD_SDRAM_LIMIT;
  wire inOpt  = addr >= `MSAD_OPT_BASE    && addr < `MSAD_OPT_LIMIT;
  wire inRo   = addr >= `MSAD_ROMRO_BASE  && addr < `MSAD_ROMRO_LIMIT;
  wire inCs0  = addr >= `MSAD_CS0_BASE;
  wire inCfl  = addr >= `MSAD_CFL_BASE;

  // Priority chain; anything not listed, or before the strap is taken, selects nothing.
  assign target =
    !mode.strapDone            ? msad_pkg::MSAD_TGT_NONE    :
    inRam                      ? msad_pkg::MSAD_TGT_RAM     :
    (inPerA || inPerB)         ? msad_pkg::MSAD_TGT_PERIPH  :
    (inSby && standbyGate)     ? msad_pkg::MSAD_TGT_STANDBY :
    inExp                      ? msad_pkg::MSAD_TGT_EXPRAM  :
    (romOn && inDfl)           ? msad_pkg::MSAD_TGT_DFLASH  :
    (romOn && inFcmd)          ? msad_pkg::MSAD_TGT_FCMD    :
    (romOn && inPerC)          ? msad_pkg::MSAD_TGT_PERIPH  :
    (romOn && inOpt)           ? msad_pkg::MSAD_TGT_OPTMEM  :
    (romOn && inRo)            ? msad_pkg::MSAD_TGT_ROMRO   :
    (romOn && inCfl)           ? msad_pkg::MSAD_TGT_CFLASH  :
    (ext && inCs)              ? msad_pkg::MSAD_TGT_EXTCS   :
    (ext && inSd)              ? msad_pkg::MSAD_TGT_SDRAM   :
    (ext && !romOn && inCs0)   ? msad_pkg::MSAD_TGT_EXTCS   :
                                 msad_pkg::MSAD_TGT_NONE;

  // Area seven sits lowest at the base; the top 16 MB block is area zero.
  wire [3:0] csSub = `MSAD_CS_TOP - {1'b0, addr[26:24]};
  assign csIndex = inCs0 ? 3'h0 : csSub[2:0];
endmodule : msad_region_dec
`default_nettype wire

// ### rtl/msad_top.sv
// Top of the mode select address decoder: request stage, decode, forwarding and read answer.
// Assumes one bus master request per cycle and targets that answer read data in the same cycle as the select.
//
// Function
// - after reset the boot mode comes from the two mode-setting pins.
// - after a single-chip pin boot, software picks single-chip, extended ROM-on or extended ROM-off; map follows it.
// - single-chip map: RAM, peripherals, standby RAM, peripherals, expansion RAM at fixed bases.
// - with ROM on, data flash from 0010_0000; reserved from 0010_8000.
// - with ROM on, flash command area to 007F_0004; peripherals from 007F_C000.
// - with ROM on, option-setting memory from FE7F_5D00; reserved from FE7F_5D80.
// - with ROM on, read-only ROM from FE7F_7D70; reserved from FE7F_7DA0.
// - with ROM on, code flash from FFE0_0000 to the top.
// - extended ROM-on adds seven 16 MB chip-select areas and 128 MB SDRAM.
// - chip-select and SDRAM hits go to the external space, never on-chip.
// - ROM-off drops flash areas and adds area zero at FF00_0000.
// - standby RAM answers only while its gate bit is set.
`timescale 1ns/1ns
`default_nettype none
`include "msad_cfg.svh"
module msad_top (
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic        clkEn,
  input  wire logic [1:0]  modePin,
  input  wire logic        runModeWr,
  input  wire logic [1:0]  runModeVal,
  input  wire logic        standbyRamGate,
  input  wire logic        reqValid,
  input  wire logic        reqWrite,
  input  wire logic [31:0] reqAddr,
  input  wire logic [31:0] reqWdata,
  input  wire logic [31:0] tgtRdata,
  output logic [1:0]       bootMode,
  output logic [1:0]       runMode,
  output logic             modeReady,
  output logic             selRam,
  output logic             selPeriph,
  output logic             selStandby,
  output logic             selExpRam,
  output logic             selDataFlash,
  output logic             selFlashCmd,
  output logic             selOptMem,
  output logic             selRomRead,
  output logic             selCodeFlash,
  output logic [7:0]       extSelect,
  output logic             sdramSelect,
  output logic             extSpace,
  output logic             fwdValid,
  output logic             fwdWrite,
  output logic [31:0]      fwdAddr,
  output logic [31:0]      fwdWdata,
  output logic             rspValid,
  output logic [31:0]      rspRdata,
  output logic             reservedHit,
  output logic             readOnlyHit
);

  // Mode information shared by the controller and the decoder.
  msad_mode_if modeBus ();

  msad_pkg::msad_target_t target;
  logic [2:0]             csIndex;

  // Request stage: the address is held one cycle so decode sees a registered value.
  logic                   reqHeld;
  logic                   reqHeldWrite;
  logic [31:0]            reqHeldAddr;
  logic [31:0]            reqHeldWdata;

  // Answer stage bookkeeping: whether the read data must be forced to zero.
  logic                   ansPending;
  logic                   ansZero;

  // Mode controller: pin strap and running mode register.
  msad_mode_ctrl u_mode (
    .clk_sys    (clk_sys),
    .rst_b      (rst_b),
    .clkEn      (clkEn),
    .modePin    (modePin),
    .runModeWr  (runModeWr),
    .runModeVal (runModeVal),
    .mode       (modeBus.ctrl)
  );

  // Address decoder for the current running mode.
  msad_region_dec u_dec (
    .addr        (reqHeldAddr),
    .standbyGate (standbyRamGate),
    .mode        (modeBus.dec),
    .target      (target),
    .csIndex     (csIndex)
  );

  // Target classification of the held request.
  wire isNone    = (target == msad_pkg::MSAD_TGT_NONE);
  wire isRam     = (target == msad_pkg::MSAD_TGT_RAM);
  wire isPeriph  = (target == msad_pkg::MSAD_TGT_PERIPH);
  wire isStandby = (target == msad_pkg::MSAD_TGT_STANDBY);
  wire isExpRam  = (target == msad_pkg::MSAD_TGT_EXPRAM);
  wire isDflash  = (target == msad_pkg::MSAD_TGT_DFLASH);
  wire isFcmd    = (target == msad_pkg::MSAD_TGT_FCMD);
  wire isOptMem  = (target == msad_pkg::MSAD_TGT_OPTMEM);
  wire isRomRo   = (target == msad_pkg::MSAD_TGT_ROMRO);
  wire isCflash  = (target == msad_pkg::MSAD_TGT_CFLASH);
  wire isExtCs   = (target == msad_pkg::MSAD_TGT_EXTCS);
  wire isSdram   = (target == msad_pkg::MSAD_TGT_SDRAM);

  // A write into the read-only ROM window is dropped like a reserved access,
  // so nothing downstream needs its own write protection for that window.
  wire roWrite   = reqHeldWrite && isRomRo;
  wire blocked   = isNone || roWrite;
  wire go        = reqHeld && !blocked;

  // External space is the chip-select and SDRAM areas only.
  wire next_extSpace = go && (isExtCs || isSdram);

  // One select line per chip-select area.
  wire [7:0] next_extSelect;
  genvar gi;
  generate
    for (gi = 0; gi < `MSAD_CS_COUNT; gi = gi + 1) begin : g_cs
      assign next_extSelect[gi] = go && isExtCs && (csIndex == 3'(gi));
    end
  endgenerate

  // On-chip selects are masked by the external qualifier implicitly: the target is one-hot.
  wire next_selRam       = go && isRam;
  wire next_selPeriph    = go && isPeriph;
  wire next_selStandby   = go && isStandby;
  wire next_selExpRam    = go && isExpRam;
  wire next_selDataFlash = go && isDflash;
  wire next_selFlashCmd  = go && isFcmd;
  wire next_selOptMem    = go && isOptMem;
  wire next_selRomRead   = go && isRomRo;
  wire next_selCodeFlash = go && isCflash;
  wire next_sdramSelect  = go && isSdram;

  // Reserved and read-only hits are reported for one cycle alongside the dropped access.
  wire next_reservedHit  = reqHeld && isNone;
  wire next_readOnlyHit  = reqHeld && roWrite;

  // Read data is zero for dropped reads and for every write answer.
  wire [31:0] next_rspRdata = ansZero ? 32'h0000_0000 : tgtRdata;

  // Request capture; a new request may arrive every cycle.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      reqHeld      <= 1'b0;
      reqHeldWrite <= 1'b0;
      reqHeldAddr  <= 32'h0000_0000;
      reqHeldWdata <= 32'h0000_0000;
    end else if (clkEn) begin
      reqHeld      <= reqValid;
      reqHeldWrite <= reqWrite;
      reqHeldAddr  <= reqAddr;
      reqHeldWdata <= reqWdata;
    end
  end

  // Target selects, one cycle wide per request.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      selRam       <= 1'b0;
      selPeriph    <= 1'b0;
      selStandby   <= 1'b0;
      selExpRam    <= 1'b0;
      selDataFlash <= 1'b0;
      selFlashCmd  <= 1'b0;
      selOptMem    <= 1'b0;
      selRomRead   <= 1'b0;
      selCodeFlash <= 1'b0;
    end else if (clkEn) begin
      selRam       <= next_selRam;
      selPeriph    <= next_selPeriph;
      selStandby   <= next_selStandby;
      selExpRam    <= next_selExpRam;
      selDataFlash <= next_selDataFlash;
      selFlashCmd  <= next_selFlashCmd;
      selOptMem    <= next_selOptMem;
      selRomRead   <= next_selRomRead;
      selCodeFlash <= next_selCodeFlash;
    end
  end

  // External space selects.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      extSelect   <= 8'h00;
      sdramSelect <= 1'b0;
      extSpace    <= 1'b0;
    end else if (clkEn) begin
      extSelect   <= next_extSelect;
      sdramSelect <= next_sdramSelect;
      extSpace    <= next_extSpace;
    end
  end

  // Forwarded access; the write strobe never leaves for a blocked access.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      fwdValid <= 1'b0;
      fwdWrite <= 1'b0;
      fwdAddr  <= 32'h0000_0000;
      fwdWdata <= 32'h0000_0000;
    end else if (clkEn) begin
      fwdValid <= go;
      fwdWrite <= go && reqHeldWrite;
      fwdAddr  <= reqHeldAddr;
      fwdWdata <= reqHeldWdata;
    end
  end

  // Error flags, one cycle wide.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      reservedHit <= 1'b0;
      readOnlyHit <= 1'b0;
    end else if (clkEn) begin
      reservedHit <= next_reservedHit;
      readOnlyHit <= next_readOnlyHit;
    end
  end

  // Answer stage: every request, taken or dropped, is answered two cycles after capture.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ansPending <= 1'b0;
      ansZero    <= 1'b0;
      rspValid   <= 1'b0;
      rspRdata   <= 32'h0000_0000;
    end else if (clkEn) begin
      ansPending <= reqHeld;
      ansZero    <= blocked || reqHeldWrite;
      rspValid   <= ansPending;
      rspRdata   <= next_rspRdata;
    end
  end

  // Mode status mirrored to the pins from local flip-flops.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      bootMode  <= 2'h0;
      runMode   <= 2'h0;
      modeReady <= 1'b0;
    end else if (clkEn) begin
      bootMode  <= modeBus.bootMode;
      runMode   <= modeBus.runMode;
      modeReady <= modeBus.strapDone;
    end
  end

endmodule : msad_top
`default_nettype wire

// ### testbench/msad_top_asserts.sv
// Concurrent checks on the ports of the mode select address decoder top.
// Assumes it is bound to msad_top and sees nothing but its ports.
`timescale 1ns/1ns
`default_nettype none
module msad_top_asserts (
  input wire logic        clk_sys,
  input wire logic        rst_b,
  input wire logic        clkEn,
  input wire logic        reqValid,
  input wire logic        standbyRamGate,
  input wire logic [1:0]  bootMode,
  input wire logic        modeReady,
  input wire logic        selRam,
  input wire logic        selPeriph,
  input wire logic        selStandby,
  input wire logic        selExpRam,
  input wire logic        selDataFlash,
  input wire logic        selFlashCmd,
  input wire logic        selOptMem,
  input wire logic        selRomRead,
  input wire logic        selCodeFlash,
  input wire logic [7:0]  extSelect,
  input wire logic        sdramSelect,
  input wire logic        extSpace,
  input wire logic        fwdValid,
  input wire logic [31:0] fwdAddr,
  input wire logic        rspValid,
  input wire logic [31:0] rspRdata,
  input wire logic        reservedHit,
  input wire logic        readOnlyHit
);
  // On-chip selects gathered once so the external-space checks stay short.
  wire logic [8:0] onChip = {selRam, selPeriph, selStandby, selExpRam, selDataFlash, selFlashCmd, selOptMem,
                             selRomRead, selCodeFlash};

  // All checks share the system clock and sleep through reset.
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  chk_answer_next: assert property (clkEn && reqValid ##1 clkEn |=> fwdValid || reservedHit || readOnlyHit)
    else $error("request got no answer");
  chk_rsp_timing: assert property (clkEn && (fwdValid || reservedHit || readOnlyHit) |=> rspValid)
    else $error("answer missing one cycle after decode");
  chk_reserved_zero: assert property (clkEn && (reservedHit || readOnlyHit) |=> rspRdata == 32'h0)
    else $error("dropped access read back nonzero");
  chk_reserved_none: assert property (reservedHit |-> !fwdValid && onChip == 9'h0 && !extSpace)
    else $error("reserved hit still selected a target");
  chk_ro_drop: assert property (readOnlyHit |-> !fwdValid && !selRomRead)
    else $error("write to read-only window forwarded");
  chk_ext_only: assert property ((extSpace || |extSelect || sdramSelect) |->
    extSpace && fwdValid && $onehot({extSelect, sdramSelect}) && onChip == 9'h0)
    else $error("external hit also selected on-chip");
  chk_standby_gate: assert property (clkEn && !standbyRamGate |=> !selStandby)
    else $error("standby RAM selected while gated off");
  chk_standby_map: assert property (selStandby |-> fwdAddr[31:13] == 19'h00052)
    else $error("standby select outside its window");
  chk_cs_area: assert property (|extSelect[7:1] |->
    fwdAddr[31:27] == 5'h00 && extSelect == 8'h01 << (4'h8 - {1'h0, fwdAddr[26:24]}))
    else $error("chip-select area does not match address");
  chk_area_zero: assert property (extSelect[0] |-> fwdAddr[31:24] == 8'hFF && !selCodeFlash)
    else $error("area zero outside its window");
  chk_sdram_map: assert property (sdramSelect |-> fwdAddr[31:27] == 5'h01)
    else $error("SDRAM select outside its window");
  chk_codeflash_map: assert property (selCodeFlash |-> fwdAddr[31:21] == 11'h7FF)
    else $error("code flash select outside its window");
  chk_flashcmd_map: assert property (selFlashCmd |-> fwdAddr inside {[32'h007E_0000:32'h007F_0003]})
    else $error("flash command select outside its window");
  chk_boot_hold: assert property (modeReady |=> modeReady && $stable(bootMode))
    else $error("boot mode changed after capture");
endmodule : msad_top_asserts

bind msad_top msad_top_asserts chk_u (.*);
`default_nettype wire

// ### testbench/msad_target_model.sv
// Stand-in for the on-chip and external targets behind the decoder.
// Assumes targets answer in the same cycle as a forwarded select, with no wait states.
`timescale 1ns/1ns
`default_nettype none
module msad_target_model #(
  parameter logic [31:0] KEY = 32'h5A5A_0000
) (
  input  wire logic        clk_sys,
  input  wire logic        fwdValid,
  input  wire logic        fwdWrite,
  input  wire logic [31:0] fwdAddr,
  output logic [31:0]      tgtRdata
);
  logic [31:0] churn = 32'h0;

  // Idle bus churns every cycle so a stale word can never pass for an answer.
  always_ff @(posedge clk_sys) churn <= churn + 32'h1;

  // Read data is a keyed copy of the address so the bench can predict it.
  assign tgtRdata = fwdValid && !fwdWrite ? fwdAddr ^ KEY : ~churn;
endmodule : msad_target_model
`default_nettype wire

// ### testbench/msad_top_tb.sv
// Self-checking bench for the mode select address decoder top.
// Assumes msad_top, the target model and the bound checker are compiled first.
`timescale 1ns/1ns
`default_nettype none
module msad_top_tb;
  localparam logic [31:0] KEY = 32'h5A5A_0000;
  logic        clk_sys, rst_b, clkEn, runModeWr, standbyRamGate, reqValid, reqWrite, modeReady, live;
  logic        selRam, selPeriph, selStandby, selExpRam, selDataFlash, selFlashCmd, selOptMem, selRomRead;
  logic        selCodeFlash, sdramSelect, extSpace, fwdValid, fwdWrite, rspValid, reservedHit, readOnlyHit;
  logic [1:0]  modePin, runModeVal, bootMode, runMode, curMode;
  logic [7:0]  extSelect;
  logic [19:0] prevSel;
  logic [31:0] reqAddr, reqWdata, tgtRdata, fwdAddr, fwdWdata, rspRdata;
  logic [31:0] seed = 32'h84EE_3960;
  logic [51:0] notes[$];
  int          err_count = 0, num_checks = 0, cyc = 0;
  logic [31:0] edges[32] = '{32'h0, 32'h3FFFC, 32'h40000, 32'h80000, 32'hA3FFC, 32'hA4000, 32'hA5FFC, 32'hA6000,
    32'h100000, 32'h107FFC, 32'h108000, 32'h7E0000, 32'h7F0000, 32'h7F0004, 32'h7FC000, 32'h800000, 32'h85FFFC,
    32'h860000, 32'h1000000, 32'h7FFFFFC, 32'h8000000, 32'hFFFFFFC, 32'h10000000, 32'hFE7F5D00, 32'hFE7F5D7C,
    32'hFE7F5D80, 32'hFE7F7D70, 32'hFE7F7D9C, 32'hFE7F7DA0, 32'hFF000000, 32'hFFE00000, 32'hFFFFFFFC};

  msad_top dut_u (.*);
  msad_target_model #(.KEY(KEY)) tgt_u (.*);

  // Free-running 100 MHz clock.
  initial begin
    clk_sys = 1'h0;
    forever #5 clk_sys = ~clk_sys;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  // Expected select vector, same bit order as the monitor packs the outputs.
  function automatic logic [19:0] tgt(input logic [31:0] a, input logic [1:0] m, input logic g, input logic w);
    logic rom;
    logic ext;
    rom = m != 2'h2;
    ext = m != 2'h0;
    tgt = 20'h8_0000;
    if (a inside {[32'h0:32'h3FFFF]}) tgt = 20'h2_0000;
    else if (a inside {[32'h80000:32'hA3FFF], [32'hA6000:32'hFFFFF]}) tgt = 20'h1_0000;
    else if (rom && a inside {[32'h7FC000:32'h7FFFFF]}) tgt = 20'h1_0000;
    else if (a inside {[32'hA4000:32'hA5FFF]}) tgt = g ? 20'h0_8000 : tgt;
    else if (a inside {[32'h800000:32'h85FFFF]}) tgt = 20'h0_4000;
    else if (rom && a inside {[32'h100000:32'h107FFF]}) tgt = 20'h0_2000;
    else if (rom && a inside {[32'h7E0000:32'h7F0003]}) tgt = 20'h0_1000;
    else if (rom && a inside {[32'hFE7F5D00:32'hFE7F5D7F]}) tgt = 20'h0_0800;
    else if (rom && a inside {[32'hFE7F7D70:32'hFE7F7D9F]}) tgt = w ? 20'h4_0000 : 20'h0_0400;
    else if (rom && a >= 32'hFFE00000) tgt = 20'h0_0200;
    else if (ext && a inside {[32'h1000000:32'h7FFFFFF]}) tgt = 20'h1 << (4'h8 - {1'h0, a[26:24]});
    else if (ext && a inside {[32'h8000000:32'hFFFFFFF]}) tgt = 20'h0_0100;
    else if (m == 2'h2 && a >= 32'hFF000000) tgt = 20'h0_0001;
  endfunction : tgt

  task automatic check(input logic [51:0] got, input logic [51:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : check

  task automatic wrap_up();
    $display("errors %0d checks %0d", err_count, num_checks);
    if (err_count == 0 && num_checks > 0 && notes.size() == 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : wrap_up

  // One request per call; clkEn low loses it, so no note is kept.
  task automatic req(input logic [31:0] a, input logic w);
    logic [31:0] r;
    logic [19:0] s;
    r = rnd();
    s = live ? tgt(a, curMode, standbyRamGate, w) : 20'h8_0000;
    @(negedge clk_sys);
    clkEn = r[2:0] != 3'h0;
    {reqValid, reqWrite, reqAddr, reqWdata} = {1'h1, w, a, r};
    if (clkEn) notes.push_back({s, (s[19:18] != 2'h0 || w) ? 32'h0 : a ^ KEY});
  endtask : req

  task automatic idle(input int n);
    @(negedge clk_sys);
    {clkEn, reqValid, runModeWr} = 3'h4;
    repeat (n) @(negedge clk_sys);
  endtask : idle

  task automatic setMode(input logic [1:0] m, input logic [1:0] exp);
    @(negedge clk_sys);
    {clkEn, reqValid, runModeWr, runModeVal, standbyRamGate} = {3'h5, m, m[0]};
    @(negedge clk_sys);
    runModeWr = 1'h0;
    @(negedge clk_sys);
    check({50'h0, runMode}, {50'h0, exp});
    curMode = exp;
  endtask : setMode

  // Reset with the pins at p, send one request before the strap is taken, then wait for it.
  task automatic doReset(input logic [1:0] p);
    int k;
    @(negedge clk_sys);
    {rst_b, modePin, live, curMode} = {1'h0, p, 1'h0, 2'h0};
    notes.delete();
    repeat (5) @(negedge clk_sys);
    rst_b = 1'h1;
    req(32'h0000_0100, 1'h0);
    idle(0);
    for (k = 0; k < 20 && modeReady !== 1'h1; k++) @(negedge clk_sys);
    check({49'h0, modeReady, bootMode}, {49'h0, 1'h1, p});
    live = 1'h1;
  endtask : doReset

  // Each answer takes the oldest note; selects come from the enabled cycle before.
  always @(posedge clk_sys) begin
    if (rst_b && clkEn) begin
      if (rspValid) check({prevSel, rspRdata}, notes.pop_front());
      prevSel <= {reservedHit, readOnlyHit, selRam, selPeriph, selStandby, selExpRam, selDataFlash, selFlashCmd,
                  selOptMem, selRomRead, selCodeFlash, sdramSelect, extSelect};
    end
  end

  // The run needs under 2000 cycles, so 6000 means a hang.
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 6000) begin
      err_count++;
      wrap_up();
    end
  end

  // Boot straps first (last one single-chip), then every running mode plus the refused code.
  initial begin
    int p;
    int m;
    logic [31:0] r;
    {rst_b, clkEn, modePin, runModeWr, runModeVal, standbyRamGate} = 8'h40;
    {reqValid, reqWrite, reqAddr, reqWdata} = 66'h0;
    for (p = 1; p < 5; p++) begin
      doReset(p[1:0]);
      setMode(2'h1, p == 4 ? 2'h1 : 2'h0);
      idle(2);
    end
    for (m = 0; m < 4; m++) begin
      setMode(m[1:0], m == 3 ? 2'h2 : m[1:0]);
      foreach (edges[i]) begin
        req(edges[i], 1'h0);
        req(edges[i], 1'h1);
      end
      repeat (40) begin
        r = rnd();
        req(edges[r[4:0]] ^ (r & 32'h0700_0FFC), r[5]);
      end
      idle(4);
    end
    wrap_up();
  end
endmodule : msad_top_tb
`default_nettype wire
